// ===== rtl/lil_pkg.sv
// Purpose: shared constants and types for the indicator led logic
// Assumes: 32-bit axi4-lite register bus, one word per register
// Notes:   colour codes fit in three bits
package lil_pkg;
    localparam int         NUM_SLOTS       = 5;
    localparam int         SIG_W           = 8;
    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_SLOT_SEL    = 8'h00;
    localparam logic [7:0] OFS_INVERT      = 8'h04;
    localparam logic [7:0] OFS_LATCH_CFG   = 8'h08;
    localparam logic [7:0] OFS_COLOUR      = 8'h0C;
    localparam logic [7:0] OFS_STATUS      = 8'h10;
    // ==========================================================
    // field positions
    localparam int         POS_LATCH_EN    = 0;
    localparam int         POS_ACK_SEL     = 8;
    localparam int         POS_ACT_COL     = 0;
    localparam int         POS_INACT_COL   = 8;
    // ==========================================================
    // reset values
    localparam logic [4:0] RST_SLOT_EN     = 5'h00;
    localparam logic [4:0] RST_INVERT      = 5'h00;
    localparam logic       RST_LATCH_EN    = 1'b1;
    localparam logic [2:0] RST_ACK_SEL     = 3'h0;
    // ==========================================================
    // timing and bus response codes
    localparam int         CLK_HZ          = 10_000_000;
    localparam int         FLASH_HALF_MS   = 500;
    localparam int         FLASH_HALF_CYC  = CLK_HZ / 1000 * FLASH_HALF_MS;
    localparam int         FLASH_CNT_W     = 23;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        COL_GREEN       = 3'h0,
        COL_RED         = 3'h1,
        COL_RED_FLASH   = 3'h2,
        COL_GREEN_FLASH = 3'h3,
        COL_OFF         = 3'h4
    } lil_colour_t;

    localparam lil_colour_t RST_ACT_COL    = COL_RED;
    localparam lil_colour_t RST_INACT_COL  = COL_OFF;

    typedef struct packed {
        logic green;
        logic red;
    } lil_led_t;
endpackage : lil_pkg

// ===== rtl/lil_indicator.sv
// Purpose: one bicolour indicator led driven from up to five inputs
// Assumes: signal sources run on aclk
// Notes:   registers over axi4-lite
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module lil_indicator (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [lil_pkg::SIG_W-1:0]   sig_in,
    input  wire logic                        flash_phase,
    output lil_pkg::lil_led_t                led,
    input  wire logic [7:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [7:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready
);
    // ==========================================================
    // configuration registers
    logic [2:0]          slot_sel_ff [lil_pkg::NUM_SLOTS];
    logic [4:0]          slot_en_ff;
    logic [4:0]          invert_ff;
    logic                latch_en_ff;
    logic [2:0]          ack_sel_ff;
    lil_pkg::lil_colour_t act_col_ff;
    lil_pkg::lil_colour_t inact_col_ff;
    logic                latched_ff;
    logic [4:0]          slot_val;
    logic                cond;
    logic                ack;
    logic                shown_act;
    lil_pkg::lil_colour_t col;

    // ==========================================================
    // axi4-lite write path
    logic                aw_got_ff;
    logic                w_got_ff;
    logic [7:0]          awaddr_ff;
    logic [31:0]         wdata_ff;
    logic [3:0]          wstrb_ff;
    logic                do_write;

    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
    assign do_write      = aw_got_ff && w_got_ff && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            awaddr_ff    <= 8'h00;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= lil_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_ff)
                    lil_pkg::OFS_SLOT_SEL,
                    lil_pkg::OFS_INVERT,
                    lil_pkg::OFS_LATCH_CFG,
                    lil_pkg::OFS_COLOUR:  s_axi_bresp <= lil_pkg::RESP_OKAY;
                    default:              s_axi_bresp <= lil_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // slot select word: bits [3*i+2:3*i] signal index, bits [20:16] slot enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_en_ff   <= lil_pkg::RST_SLOT_EN;
            invert_ff    <= lil_pkg::RST_INVERT;
            latch_en_ff  <= lil_pkg::RST_LATCH_EN;
            ack_sel_ff   <= lil_pkg::RST_ACK_SEL;
            act_col_ff   <= lil_pkg::RST_ACT_COL;
            inact_col_ff <= lil_pkg::RST_INACT_COL;
        end else if (do_write) begin
            case (awaddr_ff)
                lil_pkg::OFS_SLOT_SEL: begin
                    if (wstrb_ff[2]) slot_en_ff <= wdata_ff[20:16];
                end
                lil_pkg::OFS_INVERT: begin
                    if (wstrb_ff[0]) invert_ff <= wdata_ff[4:0];
                end
                lil_pkg::OFS_LATCH_CFG: begin
                    if (wstrb_ff[0]) latch_en_ff <= wdata_ff[lil_pkg::POS_LATCH_EN];
                    if (wstrb_ff[1]) ack_sel_ff <= wdata_ff[lil_pkg::POS_ACK_SEL +: 3];
                end
                lil_pkg::OFS_COLOUR: begin
                    // codes above off are ignored
                    if (wstrb_ff[0] && wdata_ff[2:0] <= 3'h4)
                        act_col_ff <= lil_pkg::lil_colour_t'(wdata_ff[2:0]);
                    if (wstrb_ff[1] && wdata_ff[10:8] <= 3'h4)
                        inact_col_ff <= lil_pkg::lil_colour_t'(wdata_ff[10:8]);
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // per-slot selection and inversion
    for (genvar i = 0; i < lil_pkg::NUM_SLOTS; i++) begin : g_slot
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                slot_sel_ff[i] <= 3'h0;
            end else if (do_write && awaddr_ff == lil_pkg::OFS_SLOT_SEL && wstrb_ff[0]) begin
                slot_sel_ff[i] <= wdata_ff[3*i +: 3];
            end
        end
        assign slot_val[i] = slot_en_ff[i] && (sig_in[slot_sel_ff[i]] ^ invert_ff[i]);
    end

    assign cond = |slot_val;
    assign ack  = latch_en_ff && sig_in[ack_sel_ff];

    // ==========================================================
    // latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latched_ff <= 1'b0;
        end else if (!latch_en_ff) begin
            latched_ff <= 1'b0;
        end else if (cond) begin
            latched_ff <= 1'b1;
        end else if (ack) begin
            latched_ff <= 1'b0;
        end
    end

    assign shown_act = cond || latched_ff;
    assign col       = shown_act ? act_col_ff : inact_col_ff;

    // ==========================================================
    // led drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led <= '0;
        end else begin
            case (col)
                lil_pkg::COL_GREEN:       led <= '{green: 1'b1, red: 1'b0};
                lil_pkg::COL_RED:         led <= '{green: 1'b0, red: 1'b1};
                lil_pkg::COL_RED_FLASH:   led <= '{green: 1'b0, red: flash_phase};
                lil_pkg::COL_GREEN_FLASH: led <= '{green: flash_phase, red: 1'b0};
                default:                  led <= '0;
            endcase
        end
    end

    // ==========================================================
    // axi4-lite read path
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= lil_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= lil_pkg::RESP_OKAY;
            case (s_axi_araddr)
                lil_pkg::OFS_SLOT_SEL:  s_axi_rdata <= {11'h000, slot_en_ff, 1'b0,
                    slot_sel_ff[4], slot_sel_ff[3], slot_sel_ff[2],
                    slot_sel_ff[1], slot_sel_ff[0]};
                lil_pkg::OFS_INVERT:    s_axi_rdata <= {27'h0, invert_ff};
                lil_pkg::OFS_LATCH_CFG: s_axi_rdata <= {21'h0, ack_sel_ff, 7'h00, latch_en_ff};
                lil_pkg::OFS_COLOUR:    s_axi_rdata <= {21'h0, inact_col_ff, 5'h00, act_col_ff};
                lil_pkg::OFS_STATUS:    s_axi_rdata <= {24'h0, led, 1'b0, shown_act,
                    latched_ff, cond, 1'b0, slot_val[4]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= lil_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    AST_ACTIVE: assert property (@(posedge aclk) disable iff (!aresetn)
        cond && act_col_ff == lil_pkg::COL_RED && $stable(act_col_ff)
        |=> led.red && !led.green) else $error("active colour not shown");
    AST_INACTIVE: assert property (@(posedge aclk) disable iff (!aresetn)
        !cond && !latched_ff && inact_col_ff == lil_pkg::COL_GREEN && $stable(inact_col_ff)
        |=> led.green && !led.red) else $error("inactive colour not shown");
    AST_INVERT: assert property (@(posedge aclk) disable iff (!aresetn)
        slot_en_ff[0] && invert_ff[0] && !sig_in[slot_sel_ff[0]] |-> cond)
        else $error("inverted slot ignored");
    AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        latch_en_ff && cond ##1 latch_en_ff && !ack |=> latched_ff)
        else $error("latch did not hold");
    AST_NOLATCH: assert property (@(posedge aclk) disable iff (!aresetn)
        !latch_en_ff |=> !latched_ff) else $error("latched while disabled");
    AST_ACK_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        latched_ff && cond && latch_en_ff |=> latched_ff)
        else $error("ack cleared with cause present");
    AST_ACK_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        latch_en_ff && !cond && ack |=> !latched_ff) else $error("ack did not clear");
    AST_ACK_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        !latch_en_ff && $past(!latch_en_ff) |-> shown_act == cond)
        else $error("ack acted without latching");
    AST_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        col == lil_pkg::COL_OFF |=> led == '0) else $error("led not off");
    AST_FLASH: assert property (@(posedge aclk) disable iff (!aresetn)
        col == lil_pkg::COL_RED_FLASH |=> led.red == $past(flash_phase))
        else $error("flash out of phase");
endmodule : lil_indicator

// ===== test/lil_led_model.sv
// Purpose: behavioural bicolour front-panel led
// Assumes: each colour lights while its drive bit is high
// Notes:   flags a drive with both colours lit at once
`timescale 1ns/1ps
module lil_led_model (
    input  wire lil_pkg::lil_led_t led,
    output logic [1:0]             lamp,
    output logic                   bad
);
    assign lamp = {led.green, led.red};
    assign bad  = led.green & led.red;
endmodule : lil_led_model

// ===== test/test_led_indicator_logic.sv
// Purpose: self-checking bench for the indicator led logic
// Assumes: slot i selects input i, ack on input 7
// Notes:   random configs from a fixed-seed lfsr
`timescale 1ns/1ps
module test_led_indicator_logic;
    logic              aclk, aresetn, flash_phase, bad, c;
    logic [7:0]        sig_in, awaddr, araddr;
    logic [31:0]       wdata, rdata, d;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [1:0]        bresp, rresp, r, lamp;
    logic [15:0]       lfsr, inv, en, s;
    logic [2:0]        ac, ic;
    logic [3:0]        wstrb;
    lil_pkg::lil_led_t led;
    int                n_mismatch, checked, cyc;

    lil_indicator lil_indicator_inst (.aclk(aclk), .aresetn(aresetn), .sig_in(sig_in),
        .flash_phase(flash_phase), .led(led), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    lil_led_model lil_led_model_inst (.led(led), .lamp(lamp), .bad(bad));

    // ==========================================================
    // clock and timeout
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd
    function automatic logic [1:0] exp_led(input logic [2:0] col, input logic fp);
        case (col)
            3'h0:    return 2'h2;
            3'h1:    return 2'h1;
            3'h2:    return {1'b0, fp};
            3'h3:    return {fp, 1'b0};
            default: return 2'h0;
        endcase
    endfunction : exp_led
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic lchk(input logic [1:0] exp);
        chk({30'h0, lamp}, {30'h0, exp});
        chk({31'h0, bad}, 32'h0);
    endtask : lchk
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= dat;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic drive(input logic [7:0] sv, input logic fp);
        @(posedge aclk);
        sig_in      <= sv;
        flash_phase <= fp;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask : drive
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // ==========================================================
    // main sequence
    initial begin
        {aresetn, flash_phase, sig_in, awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb      = 4'hF;
        n_mismatch = 0;
        checked    = 0;
        cyc        = 0;
        lfsr       = 16'h1834;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(lil_pkg::OFS_LATCH_CFG);
        chk(d, 32'h0000_0001);
        rd(lil_pkg::OFS_COLOUR);
        chk(d, 32'h0000_0401);
        rd(lil_pkg::OFS_INVERT);
        chk(d, 32'h0000_0000);
        rd(8'h20);
        chk({30'h0, r}, {30'h0, lil_pkg::RESP_SLVERR});
        chk(d, 32'h0000_0000);
        wr(8'h20, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, lil_pkg::RESP_SLVERR});
        drive(8'hFF, 1'b1);
        lchk(2'h0);
        wr(lil_pkg::OFS_LATCH_CFG, 32'h0000_0700);
        for (int i = 0; i < 200; i++) begin
            inv = rnd();
            en  = rnd();
            ac  = 3'(rnd() % 5);
            ic  = 3'(rnd() % 5);
            s   = rnd();
            wr(lil_pkg::OFS_SLOT_SEL, {11'h0, en[4:0], 16'h4688});
            wr(lil_pkg::OFS_INVERT, {27'h0, inv[4:0]});
            wr(lil_pkg::OFS_COLOUR, {21'h0, ic, 5'h0, ac});
            drive(s[7:0], s[8]);
            c = |((s[4:0] ^ inv[4:0]) & en[4:0]);
            lchk(exp_led(c ? ac : ic, s[8]));
        end
        wr(lil_pkg::OFS_COLOUR, 32'h0000_0400);
        wr(lil_pkg::OFS_COLOUR, 32'h0000_0606);
        rd(lil_pkg::OFS_COLOUR);
        chk(d, 32'h0000_0400);
        wstrb <= 4'hE;
        wr(lil_pkg::OFS_INVERT, 32'h0000_001F);
        wstrb <= 4'hF;
        rd(lil_pkg::OFS_INVERT);
        chk(d, {27'h0, inv[4:0]});
        wr(lil_pkg::OFS_INVERT, 32'h0);
        wr(lil_pkg::OFS_SLOT_SEL, 32'h001F_4688);
        chk({30'h0, r}, {30'h0, lil_pkg::RESP_OKAY});
        rd(lil_pkg::OFS_SLOT_SEL);
        chk(d, 32'h001F_4688);
        chk({30'h0, r}, {30'h0, lil_pkg::RESP_OKAY});
        wr(lil_pkg::OFS_LATCH_CFG, 32'h0000_0701);
        drive(8'h01, 1'b0);
        lchk(2'h2);
        drive(8'h00, 1'b0);
        lchk(2'h2);
        rd(lil_pkg::OFS_STATUS);
        chk(d, 32'h0000_0098);
        drive(8'h81, 1'b0);
        drive(8'h00, 1'b0);
        lchk(2'h2);
        drive(8'h80, 1'b0);
        lchk(2'h0);
        end_sim();
    end
endmodule : test_led_indicator_logic
